// file: hdl/host_csr_defs.vh
// Offsets, field positions and timing counts for the host control/status bank
`ifndef HOST_CSR_DEFS_VH
`define HOST_CSR_DEFS_VH

`define ADDR_W 16
`define OFF_SUBSYS_RESET 16'h0000
`define OFF_IRQ_CONV 16'h0002
`define OFF_AUDIO_CLOCK 16'h0004
`define OFF_CARD_CTRL 16'h0006
`define OFF_RX_STATUS 16'h0006
`define OFF_SYS_STATUS 16'h0002
`define CTRL_RESET_VAL 8'h00

`define AC_CS_SEL_BIT 5
`define AC_WC_SEL_HI 7
`define AC_WC_SEL_LO 6
`define IC_DIN_MASK_BIT 6

`define WC_INT_441 2'h0
`define WC_INT_48 2'h1
`define WC_EXT 2'h2
`define WC_OFF 2'h3

`define ERR_NONE 3'h0
`define ERR_VALIDITY 3'h1
`define ERR_CONFIDENCE 3'h2
`define ERR_SLIP 3'h3
`define ERR_CRC 3'h4
`define ERR_PARITY 3'h5
`define ERR_BIPHASE 3'h6
`define ERR_NO_LOCK 3'h7

// Select high must last more than this many recovered master clocks
`define CLR_MCK_CYCLES 4'h8
`define CLR_CNT_W 4

`endif

// file: hdl/pin_sync3.v
// Three-stage synchroniser, change accepted when stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
    parameter W = 1
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Pins
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    reg [W-1:0] s1_reg;
    reg [W-1:0] s2_reg;
    reg [W-1:0] s3_reg;
    genvar i;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= {W{1'b0}};
            s2_reg <= {W{1'b0}};
            s3_reg <= {W{1'b0}};
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    dout[i] <= 1'b0;
                end else if (s2_reg[i] == s3_reg[i]) begin
                    dout[i] <= s3_reg[i];
                end
            end
        end
    endgenerate
endmodule

// file: hdl/rx_error_latch.v
// Priority error-code latch, cleared by a long enough select-high period
`timescale 1ns/1ps
`include "host_csr_defs.vh"
module rx_error_latch (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Synchronised receiver side
    input wire [7:0] err_events,
    input wire mck_tick,
    input wire select_high,
    // Result
    output reg [2:0] err_code,
    output reg err_flag
);
    reg [`CLR_CNT_W-1:0] clr_cnt_reg;
    reg [2:0] hit_code;
    wire clr_done;
    integer k;

    // Highest index wins: validity lowest, loss of lock highest
    always @* begin
        hit_code = `ERR_NONE;
        for (k = 1; k < 8; k = k + 1) begin
            if (err_events[k]) begin
                hit_code = k[2:0];
            end
        end
    end

    // Count master-clock ticks while select stays high; drop resets the count
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clr_cnt_reg <= {`CLR_CNT_W{1'b0}};
        end else if (!select_high) begin
            clr_cnt_reg <= {`CLR_CNT_W{1'b0}};
        end else if (mck_tick && !clr_done) begin
            clr_cnt_reg <= clr_cnt_reg + 1'b1;
        end
    end
    assign clr_done = (clr_cnt_reg > `CLR_MCK_CYCLES);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_code <= `ERR_NONE;
            err_flag <= 1'b0;
        end else begin
            // A new error ranked above the held code outranks the clear in the same cycle
            if (hit_code > err_code) begin
                err_code <= hit_code;
            end else if (clr_done) begin
                err_code <= `ERR_NONE;
            end
            err_flag <= (hit_code != `ERR_NONE) ||
                ((err_code != `ERR_NONE) && !clr_done);
        end
    end
endmodule

// file: hdl/host_control_status_registers.v
// Host control and status register bank of the effects I/O board
//
// Functional notes
// - Select high puts receiver channel-status bits on status two bits 5:0.
// - Select low shows error code on bits 2:0, frequency on 5:3.
// - Status two bit 6 always shows the receiver error flag.
// - Channel-status order: pro, non-audio, copy, emphasis, original, ignorant category.
// - Select high drives the inverted select low onto the sub-frame pin.
// - Error flag AND digital input mask drives the host non-maskable interrupt.
// - Error code latched and held; highest priority shown, loss of lock top.
// - Code clears after select high over eight master clocks; host holds long.
// - Control zero: master reset, output valid, mute, I/O, mode, DSP, effects, slave.
// - Control one: DSP mask, input mask, LED, calibrate, DAC reset, priority bits.
// - Control two: wordclock select, status select, transmit status bits, frequency.
// - Control three: card register select, driver disable, flash VPP, spare, page.
// - Status two is read-only; bit 7 is pedal converter done, low.
// - Status one: display busy, DMA done, battery, overloads, lock, interrupts.
// - Wordclock select code 2 (external) makes recovered 256x clock the audio master clock.
// - Error codes 000 none through 111 loss of lock.
// - Frequency codes 000 out of range through 111 32 kHz tight.
// - Wordclock select: 44.1, 48, external, held low.
`timescale 1ns/1ps
`include "host_csr_defs.vh"
module host_control_status_registers (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Host I/O bus
    input wire [`ADDR_W-1:0] io_addr,
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_wdata,
    output reg [7:0] io_rdata,
    // Receiver pins
    input wire rx_error_flag,
    input wire [7:0] rx_error_events,
    input wire [2:0] rx_freq_report,
    input wire [5:0] rx_chan_status_pins,
    input wire recovered_master_clock,
    output reg rx_cs_select_n,
    output reg rx_subframe_select_pin,
    // Status pins
    input wire pedal_adc_done_n,
    input wire display_busy,
    input wire dma_complete_n,
    input wire battery_low,
    input wire effects_overload_n,
    input wire dsp_overload_n,
    input wire dsp_pll_lock_n,
    input wire dsp_interrupt,
    input wire slave_host_interrupt,
    // Clock sources
    input wire int_clk_441,
    input wire int_clk_48,
    input wire recovered_256x_clock,
    input wire gated_ref_clock,
    output reg [1:0] wordclock_source_sel,
    output reg master_clock_out,
    // Interrupt
    output reg host_nonmaskable_irq,
    // Control register 0 outputs
    output reg host_master_reset,
    output reg output_valid,
    output reg mute_n,
    output reg digital_io_reset_n,
    output reg dsp_mode_force,
    output reg dsp_reset_n,
    output reg effects_chip_reset_n,
    output reg slave_cpu_reset_n,
    // Control register 1 outputs
    output reg dsp_irq_mask_n,
    output reg digital_in_irq_mask,
    output reg panel_led_enable,
    output reg converter_calibrate,
    output reg dac_reset_n,
    output reg [2:0] irq_priority_bit,
    // Control register 2 outputs
    output reg rx_chan_status_select,
    output reg tx_chan_status_15_n,
    output reg tx_chan_status_3_n,
    output reg tx_chan_status_2_n,
    output reg [1:0] tx_freq_control,
    // Control register 3 outputs
    output reg card_reg_select_n,
    output reg card_driver_disable_n,
    output reg flash_vpp_enable,
    output reg card_spare,
    output reg [3:0] card_page_addr
);
    ////////////////////////////////////////////////////////////////////////////
    // Write-only control registers
    reg [7:0] subsystem_reset_control_reg;
    reg [7:0] interrupt_and_converter_control_reg;
    reg [7:0] digital_audio_clock_control_reg;
    reg [7:0] memory_card_control_reg;

    // Cleared to all-low so every active-low reset is asserted, host master reset stays off, and audio is muted
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            subsystem_reset_control_reg <= `CTRL_RESET_VAL;
            interrupt_and_converter_control_reg <= `CTRL_RESET_VAL;
            digital_audio_clock_control_reg <= `CTRL_RESET_VAL;
            memory_card_control_reg <= `CTRL_RESET_VAL;
        end else if (io_wr) begin
            case (io_addr)
                `OFF_SUBSYS_RESET: begin
                    subsystem_reset_control_reg <= io_wdata;
                end
                `OFF_IRQ_CONV: begin
                    interrupt_and_converter_control_reg <= io_wdata;
                end
                `OFF_AUDIO_CLOCK: begin
                    digital_audio_clock_control_reg <= io_wdata;
                end
                `OFF_CARD_CTRL: begin
                    memory_card_control_reg <= io_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    always @* begin
        // Control zero: subsystem resets and output gating
        host_master_reset = subsystem_reset_control_reg[7];
        output_valid = subsystem_reset_control_reg[6];
        mute_n = subsystem_reset_control_reg[5];
        digital_io_reset_n = subsystem_reset_control_reg[4];
        dsp_mode_force = subsystem_reset_control_reg[3];
        dsp_reset_n = subsystem_reset_control_reg[2];
        effects_chip_reset_n = subsystem_reset_control_reg[1];
        slave_cpu_reset_n = subsystem_reset_control_reg[0];
        // Control one: masks, converter control, priority
        dsp_irq_mask_n = interrupt_and_converter_control_reg[7];
        digital_in_irq_mask = interrupt_and_converter_control_reg[6];
        panel_led_enable = interrupt_and_converter_control_reg[5];
        converter_calibrate = interrupt_and_converter_control_reg[4];
        dac_reset_n = interrupt_and_converter_control_reg[3];
        irq_priority_bit = interrupt_and_converter_control_reg[2:0];
        // Control two: clock source, receiver select, transmit status
        wordclock_source_sel = digital_audio_clock_control_reg[7:6];
        rx_chan_status_select = digital_audio_clock_control_reg[5];
        tx_chan_status_15_n = digital_audio_clock_control_reg[4];
        tx_chan_status_3_n = digital_audio_clock_control_reg[3];
        tx_chan_status_2_n = digital_audio_clock_control_reg[2];
        tx_freq_control = digital_audio_clock_control_reg[1:0];
        // Control three: memory card access
        card_reg_select_n = memory_card_control_reg[7];
        card_driver_disable_n = memory_card_control_reg[6];
        flash_vpp_enable = memory_card_control_reg[5];
        card_spare = memory_card_control_reg[4];
        card_page_addr = memory_card_control_reg[3:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    wire [13:0] st_sync;
    wire [7:0] ev_sync;
    wire [8:0] rx_sync;
    wire mck_sync;
    reg mck_prev_reg;
    wire mck_rise;

    pin_sync3 #(.W(14)) u_sync_status (
        .clk(clk),
        .rst_n(rst_n),
        .din({
            pedal_adc_done_n,
            display_busy,
            dma_complete_n,
            battery_low,
            effects_overload_n,
            dsp_overload_n,
            dsp_pll_lock_n,
            dsp_interrupt,
            slave_host_interrupt,
            rx_error_flag,
            4'h0
        }),
        .dout(st_sync)
    );
    pin_sync3 #(.W(8)) u_sync_events (
        .clk(clk),
        .rst_n(rst_n),
        .din(rx_error_events),
        .dout(ev_sync)
    );
    pin_sync3 #(.W(9)) u_sync_rx (
        .clk(clk),
        .rst_n(rst_n),
        .din({rx_freq_report, rx_chan_status_pins}),
        .dout(rx_sync)
    );
    // Master clock sampled as a level; only valid at or below clk/4
    pin_sync3 #(.W(1)) u_sync_mck (
        .clk(clk),
        .rst_n(rst_n),
        .din(recovered_master_clock),
        .dout(mck_sync)
    );

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mck_prev_reg <= 1'b0;
        end else begin
            mck_prev_reg <= mck_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Error code latch and clear sequence
    wire [2:0] err_code;
    wire err_any;

    assign mck_rise = mck_sync & ~mck_prev_reg;

    rx_error_latch u_err (
        .clk(clk),
        .rst_n(rst_n),
        .err_events(ev_sync),
        .mck_tick(mck_rise),
        .select_high(rx_chan_status_select),
        .err_code(err_code),
        .err_flag(err_any)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Status registers and read path
    wire rx_flag_s = st_sync[4];
    reg [7:0] receiver_status;
    reg [7:0] system_status;

    always @* begin
        system_status[7] = st_sync[12];
        system_status[6] = st_sync[11];
        system_status[5] = st_sync[10];
        system_status[4] = st_sync[9];
        system_status[3] = st_sync[8];
        system_status[2] = st_sync[7];
        system_status[1] = st_sync[6];
        system_status[0] = st_sync[5];
        receiver_status[7] = st_sync[13];
        receiver_status[6] = rx_flag_s;
        if (rx_chan_status_select) begin
            // First four active low, last two active high
            receiver_status[0] = rx_sync[0];
            receiver_status[1] = rx_sync[1];
            receiver_status[2] = rx_sync[2];
            receiver_status[3] = rx_sync[3];
            receiver_status[4] = rx_sync[4];
            receiver_status[5] = rx_sync[5];
        end else begin
            // Host must drop the select before reading here
            receiver_status[2:0] = err_code;
            receiver_status[5:3] = rx_sync[8:6];
        end
    end

    // Reads of a write-only offset return zero, except the shared 0x0002 and 0x0006 slots
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            io_rdata <= 8'h00;
        end else if (io_rd) begin
            case (io_addr)
                `OFF_RX_STATUS: begin
                    io_rdata <= receiver_status;
                end
                `OFF_SYS_STATUS: begin
                    io_rdata <= system_status;
                end
                // Write-only controls cannot be read back
                `OFF_SUBSYS_RESET, `OFF_AUDIO_CLOCK: begin
                    io_rdata <= 8'h00;
                end
                default: begin
                    io_rdata <= 8'h00;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sub-frame select and interrupt
    always @* begin
        rx_cs_select_n = ~rx_chan_status_select;
        rx_subframe_select_pin = rx_cs_select_n & gated_ref_clock;
        // Latched code keeps the request up until the host clears it
        host_nonmaskable_irq = (rx_flag_s | err_any) & digital_in_irq_mask;
    end

    // Master-clock mux; the last code parks the clock low
    always @* begin
        case (wordclock_source_sel)
            `WC_INT_441: begin
                master_clock_out = int_clk_441;
            end
            `WC_INT_48: begin
                master_clock_out = int_clk_48;
            end
            `WC_EXT: begin
                master_clock_out = recovered_256x_clock;
            end
            default: begin
                master_clock_out = 1'b0;
            end
        endcase
    end
endmodule

// file: dv/host_csr_asserts.sv
// Port-level concurrent checks for the host control/status register bank
`timescale 1ns/1ps
module host_csr_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Host writes
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    // Receiver select and interrupt
    input wire logic rx_chan_status_select,
    input wire logic rx_cs_select_n,
    input wire logic rx_subframe_select_pin,
    input wire logic digital_in_irq_mask,
    input wire logic host_nonmaskable_irq,
    // Clock selection
    input wire logic [1:0] wordclock_source_sel,
    input wire logic master_clock_out,
    input wire logic recovered_256x_clock
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    chk_sel_inverted: assert property (
        rx_cs_select_n == !rx_chan_status_select) else $error("select copy not inverted");
    chk_subframe_low: assert property (
        rx_chan_status_select |-> !rx_subframe_select_pin) else $error("subframe pin not low");
    chk_ctrl2_write: assert property (
        io_wr && io_addr == 16'h0004 |=>
        {wordclock_source_sel, rx_chan_status_select} == $past(io_wdata[7:5]))
        else $error("clock control write lost");
    chk_ctrl2_hold: assert property (
        !(io_wr && io_addr == 16'h0004) |=> $stable(rx_chan_status_select))
        else $error("select changed without write");
    chk_mask_write: assert property (
        io_wr && io_addr == 16'h0002 |=> digital_in_irq_mask == $past(io_wdata[6]))
        else $error("input mask write lost");
    // Two cycles of low mask, though the combinational interrupt output needs only one
    chk_nmi_masked: assert property (
        !digital_in_irq_mask [*2] |-> !host_nonmaskable_irq) else $error("nmi while masked");
    chk_ext_clock: assert property (
        wordclock_source_sel == 2'h2 |-> master_clock_out == recovered_256x_clock)
        else $error("external clock not selected");
    chk_clock_off: assert property (
        wordclock_source_sel == 2'h3 |-> !master_clock_out) else $error("clock not held low");
endmodule

// file: dv/host_io_model.sv
// Host CPU model: I/O strobes plus shadow copies of the write-only controls
`timescale 1ns/1ps
module host_io_model (
    // Clock
    input wire logic clk,
    // Host I/O bus
    output logic [15:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata
);
    logic [7:0] shadow [0:3] = '{8'h00, 8'h00, 8'h00, 8'h00};
    initial begin
        {io_addr, io_wr, io_rd, io_wdata} = '0;
    end
    task automatic io_write(input logic [15:0] addr, input logic [7:0] data);
        @(posedge clk);
        io_addr <= addr;
        io_wdata <= data;
        io_wr <= 1'b1;
        @(posedge clk);
        io_wr <= 1'b0;
        if (addr < 16'h0008 && !addr[0]) shadow[addr[2:1]] = data;
    endtask
    task automatic io_read(input logic [15:0] addr, output logic [7:0] data);
        @(posedge clk);
        io_addr <= addr;
        io_rd <= 1'b1;
        @(posedge clk);
        io_rd <= 1'b0;
        // Registered data stands from the edge that took the strobe
        @(posedge clk);
        data = io_rdata;
    endtask
    // Controls cannot be read back, so bit changes work on the shadow
    task automatic set_bits(input int idx, input logic [7:0] mask, input logic [7:0] val);
        io_write(16'(2 * idx), (shadow[idx] & ~mask) | (val & mask));
    endtask
    // Select held high for a while, then low again so error bits can be read
    task automatic clear_errors(input int hold);
        set_bits(2, 8'h20, 8'h20);
        repeat (hold) @(posedge clk);
        set_bits(2, 8'h20, 8'h00);
    endtask
endmodule

// file: dv/host_control_status_registers_tb_top.sv
// Self-checking bench for the host control/status register bank
`timescale 1ns/1ps
module host_control_status_registers_tb_top;
    logic clk, rst_n, rx_error_flag, pedal_adc_done_n;
    logic [7:0] rx_error_events, st1, d;
    logic [2:0] rx_freq_report, q;
    logic [5:0] rx_chan_status_pins;
    logic [3:0] src, mck_div;
    wire [15:0] io_addr;
    wire io_wr, io_rd;
    wire [7:0] io_wdata, io_rdata;
    wire [7:0] ctrl [0:3];
    wire rx_cs_select_n, rx_subframe_select_pin, master_clock_out, host_nonmaskable_irq;
    wire recovered_master_clock = mck_div[2];
    logic [7:0] pat [0:1] = '{8'hA5, 8'h5A};
    int num_errors = 0, check_count = 0, cycles = 0;
    host_io_model host (.clk, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata);
    host_control_status_registers dut (.clk, .rst_n, .io_addr, .io_wr, .io_rd, .io_wdata,
        .io_rdata, .rx_error_flag, .rx_error_events, .rx_freq_report, .rx_chan_status_pins,
        .recovered_master_clock, .rx_cs_select_n, .rx_subframe_select_pin, .pedal_adc_done_n,
        .display_busy(st1[7]), .dma_complete_n(st1[6]), .battery_low(st1[5]),
        .effects_overload_n(st1[4]), .dsp_overload_n(st1[3]), .dsp_pll_lock_n(st1[2]),
        .dsp_interrupt(st1[1]), .slave_host_interrupt(st1[0]), .int_clk_441(src[0]),
        .int_clk_48(src[1]), .recovered_256x_clock(src[2]), .gated_ref_clock(src[3]),
        .wordclock_source_sel(ctrl[2][7:6]), .master_clock_out, .host_nonmaskable_irq,
        .host_master_reset(ctrl[0][7]), .output_valid(ctrl[0][6]), .mute_n(ctrl[0][5]),
        .digital_io_reset_n(ctrl[0][4]), .dsp_mode_force(ctrl[0][3]), .dsp_reset_n(ctrl[0][2]),
        .effects_chip_reset_n(ctrl[0][1]), .slave_cpu_reset_n(ctrl[0][0]),
        .dsp_irq_mask_n(ctrl[1][7]), .digital_in_irq_mask(ctrl[1][6]),
        .panel_led_enable(ctrl[1][5]), .converter_calibrate(ctrl[1][4]),
        .dac_reset_n(ctrl[1][3]), .irq_priority_bit(ctrl[1][2:0]),
        .rx_chan_status_select(ctrl[2][5]), .tx_chan_status_15_n(ctrl[2][4]),
        .tx_chan_status_3_n(ctrl[2][3]), .tx_chan_status_2_n(ctrl[2][2]),
        .tx_freq_control(ctrl[2][1:0]), .card_reg_select_n(ctrl[3][7]),
        .card_driver_disable_n(ctrl[3][6]), .flash_vpp_enable(ctrl[3][5]),
        .card_spare(ctrl[3][4]), .card_page_addr(ctrl[3][3:0]));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (num_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always #12.5 clk = ~clk;
    // Master clock at one eighth of clk, slow enough for the sampled count
    always @(posedge clk) begin
        mck_div <= mck_div + 4'h1;
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {clk, rst_n, rx_error_flag, pedal_adc_done_n, rx_error_events, rx_freq_report} = '0;
        {rx_chan_status_pins, st1, src, mck_div} = '0;
        repeat (8) @(posedge clk);
        for (int i = 0; i < 4; i++) check(ctrl[i], 8'h00);
        rst_n <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 4; i++) begin
                host.io_write(16'(2 * i), pat[p] ^ 8'(i));
                #1 check(ctrl[i], pat[p] ^ 8'(i));
            end
        end
        host.io_write(16'h0008, 8'hFF);
        #1 for (int i = 0; i < 4; i++) check(ctrl[i], 8'h5A ^ 8'(i));
        host.io_read(16'h0000, d);
        check(d, 8'h00);
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            st1 <= pat[p];
            repeat (6) @(posedge clk);
            host.io_read(16'h0002, d);
            check(d, pat[p]);
        end
        host.set_bits(2, 8'h20, 8'h20);
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            {pedal_adc_done_n, rx_error_flag, rx_chan_status_pins} <= pat[p];
            src <= 4'hF;
            repeat (6) @(posedge clk);
            host.io_read(16'h0006, d);
            check(d, pat[p]);
            check(8'({rx_cs_select_n, rx_subframe_select_pin}), 8'h00);
        end
        @(posedge clk);
        {pedal_adc_done_n, rx_error_flag} <= 2'h2;
        host.set_bits(2, 8'h20, 8'h00);
        #1 check(8'({rx_cs_select_n, rx_subframe_select_pin}), 8'h03);
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            rx_error_events[k] <= (k > 0);
            rx_freq_report <= 3'(k);
            repeat (6) @(posedge clk);
            host.io_read(16'h0006, d);
            check(d, {2'h2, 3'(k), 3'(k)});
        end
        @(posedge clk);
        rx_error_events <= 8'h00;
        // Short select pulse must leave the code, a long one clears it
        for (int h = 0; h < 2; h++) begin
            host.clear_errors(h ? 100 : 24);
            host.io_read(16'h0006, d);
            check(d, h ? 8'hB8 : 8'hBF);
        end
        @(posedge clk);
        rx_error_events <= 8'h08;
        repeat (6) @(posedge clk);
        rx_error_events <= 8'h02;
        repeat (6) @(posedge clk);
        host.io_read(16'h0006, d);
        check(d, 8'hBB);
        @(posedge clk);
        rx_error_flag <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            host.set_bits(1, 8'h40, m ? 8'h40 : 8'h00);
            repeat (6) @(posedge clk);
            #1 check(8'(host_nonmaskable_irq), 8'(m));
        end
        for (int s = 0; s < 4; s++) begin
            host.set_bits(2, 8'hC0, 8'(s << 6));
            for (int p = 0; p < 2; p++) begin
                q = p ? 3'h2 : 3'h5;
                @(posedge clk);
                src[2:0] <= q;
                #1 check(8'(master_clock_out), 8'(s < 3 && q[s]));
            end
        end
        stop_test();
    end
endmodule
bind host_control_status_registers host_csr_asserts chk (.clk, .rst_n, .io_addr, .io_wr,
    .io_wdata, .rx_chan_status_select, .rx_cs_select_n, .rx_subframe_select_pin,
    .digital_in_irq_mask, .host_nonmaskable_irq, .wordclock_source_sel, .master_clock_out,
    .recovered_256x_clock);
